// File: hdl/wdt_irq_params.svh
`ifndef WDT_IRQ_PARAMS_SVH
`define WDT_IRQ_PARAMS_SVH

// ==========================================
// clock and watchdog timing
`define CLK_MHZ 25
`define WDT_BASE0_US 3500
`define WDT_BASE1_US 15000
`define WDT_BASE2_US 60000
`define WDT_BASE3_US 250000

// ==========================================
// register byte offsets
`define OFS_POWER_CTRL 8'h00
`define OFS_PRESCALE 8'h04
`define OFS_IRQ_FLAG 8'h08
`define OFS_IRQ_ENABLE 8'h0C
`define OFS_STATUS 8'h10
`define OFS_PORTB_CFG 8'h14

// ==========================================
// field positions
`define BIT_RUN_EN 7
`define BIT_ASSIGN 3
`define BIT_UPCNT 0
`define BIT_PORTCHG 1
`define BIT_EXTIRQ 2
`define BIT_DNCNT 3
`define BIT_WDTIRQ 6
`define BIT_TIMEOUT 4
`define BIT_GIE 0
`define BIT_EIS 16
`define BIT_EDGE 17

// ==========================================
// reset values and vectors
`define FLAG_MASK 8'h4F
`define RST_RUN_EN 1'b1
`define RST_TIMEOUT 1'b1
`define VEC_SOFT 11'h001
`define VEC_HARD 11'h008
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: hdl/wdt_irq_pkg.sv
package wdt_irq_pkg;
  typedef enum logic [2:0] {
    SEL_POWER = 3'b000,
    SEL_PRESCALE = 3'b001,
    SEL_FLAG = 3'b010,
    SEL_ENABLE = 3'b011,
    SEL_STATUS = 3'b100,
    SEL_PORTB = 3'b101,
    SEL_NONE = 3'b111
  } reg_sel_t;
  typedef logic [7:0] irq_bits_t;
endpackage

// File: hdl/wdt_ctl_if.sv
`timescale 1ns/1ps
interface wdt_ctl_if;
  logic runEn;
  logic clear;
  logic [1:0] periodSel;
  logic assignSel;
  logic [2:0] rate;
  logic irqMode;
  logic timeout;
  modport ctl (output runEn, clear, periodSel, assignSel, rate, irqMode, input timeout);
  modport wdt (input runEn, clear, periodSel, assignSel, rate, irqMode, output timeout);
endinterface

// File: hdl/wdt_counter.sv
`timescale 1ns/1ps
`include "wdt_irq_params.svh"
module wdt_counter #(
  parameter int unsigned CYC0 = `WDT_BASE0_US * `CLK_MHZ,
  parameter int unsigned CYC1 = `WDT_BASE1_US * `CLK_MHZ,
  parameter int unsigned CYC2 = `WDT_BASE2_US * `CLK_MHZ,
  parameter int unsigned CYC3 = `WDT_BASE3_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rstn,
  wdt_ctl_if.wdt w
);
  // ==========================================
  // base period and prescaler
  logic [22:0] baseCnt_r;
  logic [7:0] psc_r;
  logic [22:0] baseLast;
  logic [8:0] divide;
  logic baseWrap;

  always_comb begin
    case (w.periodSel)
      2'd0: baseLast = 23'(CYC0 - 1);
      2'd1: baseLast = 23'(CYC1 - 1);
      2'd2: baseLast = 23'(CYC2 - 1);
      default: baseLast = 23'(CYC3 - 1);
    endcase
  end

  // with the assign bit at one, irq mode divides one step further than reset mode; at zero both divide by 1
  always_comb begin
    if (!w.assignSel) begin
      divide = 9'h001;
    end else if (w.irqMode) begin
      divide = 9'(9'h002 << w.rate);
    end else begin
      divide = 9'(9'h001 << w.rate);
    end
  end

  assign baseWrap = w.runEn && (baseCnt_r == baseLast);
  assign w.timeout = baseWrap && ({1'b0, psc_r} == 9'(divide - 9'h001));

  // no sleep input: counting ignores standby and halt on purpose
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      baseCnt_r <= 23'h00_0000;
    end else if (w.clear || baseWrap) begin
      baseCnt_r <= 23'h00_0000;
    end else if (w.runEn) begin
      baseCnt_r <= baseCnt_r + 23'h00_0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psc_r <= 8'h00;
    end else if (w.clear || w.timeout) begin
      psc_r <= 8'h00;
    end else if (baseWrap) begin
      psc_r <= psc_r + 8'h01;
    end
  end

  a_clear_zeroes: assert property (@(posedge clk) disable iff (!rstn)
    w.clear |=> (baseCnt_r == 23'h00_0000) && (psc_r == 8'h00))
    else $error("watchdog clear did not zero counters");
endmodule

// File: hdl/watchdog_and_interrupt_unit.sv
`timescale 1ns/1ps
`include "wdt_irq_params.svh"
// Notes on behaviour
// - run-enable bit gates watchdog counting when the option enables it
// - timeout resets the device or requests an interrupt, per option
// - every watchdog timeout clears the timeout status flag
// - base period 3.5, 15, 60 or 250 ms from a two-bit option
// - assign bit at one routes the shared prescaler to the watchdog
// - rate field divides 1..128 in reset mode, 2..256 in irq mode
// - watchdog-clear with assign bit at one zeroes counter and prescaler, sets timeout status
// - irq mode expiry sets watchdog flag; request needs enable and global
// - watchdog keeps counting in standby and halt
// - software interrupt vectors to 0x001 always and clears global enable
// - enable/disable instructions set/clear global enable; gates hardware irqs
// - return-from-isr sets global enable and resumes
// - each hardware event sets a sticky flag cleared by writing zero
// - a flag reads set only when its enable bit is one
// - pending enabled flag with global enable vectors to 0x008, clears global
// - up-counter overflow sets its flag
// - down-counter underflow sets its flag
// - level change on enabled input port-B pins sets port-change flag
// - external irq selection disables change detection on pin 0
// - selected edge on pin 0 sets external irq flag
// - up-counter flag and enable sit at bit 0
// - down-counter flag and enable sit at bit 3
module watchdog_and_interrupt_unit
  import wdt_irq_pkg::*;
#(
  parameter int unsigned WDT_CYC0 = `WDT_BASE0_US * `CLK_MHZ,
  parameter int unsigned WDT_CYC1 = `WDT_BASE1_US * `CLK_MHZ,
  parameter int unsigned WDT_CYC2 = `WDT_BASE2_US * `CLK_MHZ,
  parameter int unsigned WDT_CYC3 = `WDT_BASE3_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cfgWdtEnable,
  input wire logic cfgWdtIrqMode,
  input wire logic [1:0] cfgWdtPeriod,
  input wire logic instrBoundary,
  input wire logic watchdogClearInstr,
  input wire logic enableIrqInstr,
  input wire logic disableIrqInstr,
  input wire logic softIrqInstr,
  input wire logic returnFromIsrInstr,
  input wire logic upcounterOverflow,
  input wire logic downcounterUnderflow,
  input wire logic [7:0] portBPins,
  output logic vectorValid,
  output logic [10:0] vectorAddr,
  output logic wdtResetReq,
  output logic irqPending
);
  // ==========================================
  // address decode
  function automatic reg_sel_t decodeAddr(input logic [7:0] a);
    case (a)
      `OFS_POWER_CTRL: decodeAddr = SEL_POWER;
      `OFS_PRESCALE: decodeAddr = SEL_PRESCALE;
      `OFS_IRQ_FLAG: decodeAddr = SEL_FLAG;
      `OFS_IRQ_ENABLE: decodeAddr = SEL_ENABLE;
      `OFS_STATUS: decodeAddr = SEL_STATUS;
      `OFS_PORTB_CFG: decodeAddr = SEL_PORTB;
      default: decodeAddr = SEL_NONE;
    endcase
  endfunction

  // ==========================================
  // state
  logic runEn_r;
  logic assignSel_r;
  logic [2:0] rate_r;
  irq_bits_t flags_r;
  irq_bits_t flags_nxt;
  irq_bits_t enable_r;
  logic gie_r;
  logic timeoutStatus_r;
  logic [7:0] changeEn_r;
  logic [7:0] inputMask_r;
  logic eis_r;
  logic edgeSel_r;
  logic optEnable_r;
  logic optIrqMode_r;
  logic [1:0] optPeriod_r;
  logic strapDone_r;
  logic [7:0] pinMeta_r;
  logic [7:0] pinSync_r;
  logic [7:0] pinPrev_r;
  logic [1:0] primeCnt_r;

  // ==========================================
  // write channel: address and data latched separately
  logic awHeld_r;
  logic [7:0] awAddr_r;
  logic wHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wrFire;
  reg_sel_t wrSel;

  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
  assign wrSel = decodeAddr(awAddr_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wrFire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wrSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================
  // read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rdMux;
  reg_sel_t rdSel;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rdSel = decodeAddr(s_axi_araddr);

  always_comb begin
    rdMux = 32'h0000_0000;
    case (rdSel)
      SEL_POWER: rdMux[`BIT_RUN_EN] = runEn_r;
      SEL_PRESCALE: rdMux[3:0] = {assignSel_r, rate_r};
      SEL_FLAG: rdMux[7:0] = flags_r & enable_r;
      SEL_ENABLE: rdMux[7:0] = enable_r;
      SEL_STATUS: begin
        rdMux[`BIT_TIMEOUT] = timeoutStatus_r;
        rdMux[`BIT_GIE] = gie_r;
      end
      SEL_PORTB: rdMux[17:0] = {edgeSel_r, eis_r, inputMask_r, changeEn_r};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdMux;
      rresp_r <= (rdSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================
  // software-written control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      runEn_r <= `RST_RUN_EN;
      assignSel_r <= 1'b0;
      rate_r <= 3'h0;
      enable_r <= 8'h00;
      changeEn_r <= 8'h00;
      inputMask_r <= 8'h00;
      eis_r <= 1'b0;
      edgeSel_r <= 1'b0;
    end else if (wrFire) begin
      case (wrSel)
        SEL_POWER: if (wStrb_r[0]) runEn_r <= wData_r[`BIT_RUN_EN];
        SEL_PRESCALE: if (wStrb_r[0]) {assignSel_r, rate_r} <= wData_r[3:0];
        SEL_ENABLE: if (wStrb_r[0]) enable_r <= wData_r[7:0] & `FLAG_MASK;
        SEL_PORTB: begin
          if (wStrb_r[0]) changeEn_r <= wData_r[7:0];
          if (wStrb_r[1]) inputMask_r <= wData_r[15:8];
          if (wStrb_r[2]) {edgeSel_r, eis_r} <= wData_r[`BIT_EDGE:`BIT_EIS];
        end
        default: ;
      endcase
    end
  end

  // configuration options, caught once after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strapDone_r <= 1'b0;
      optEnable_r <= 1'b0;
      optIrqMode_r <= 1'b0;
      optPeriod_r <= 2'b00;
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      optEnable_r <= cfgWdtEnable;
      optIrqMode_r <= cfgWdtIrqMode;
      optPeriod_r <= cfgWdtPeriod;
    end
  end

  // ==========================================
  // watchdog
  wdt_ctl_if wdtBus ();
  logic wdtTimeout;

  assign wdtBus.runEn = strapDone_r && optEnable_r && runEn_r;
  assign wdtBus.clear = watchdogClearInstr && assignSel_r;
  assign wdtBus.periodSel = optPeriod_r;
  assign wdtBus.assignSel = assignSel_r;
  assign wdtBus.rate = rate_r;
  assign wdtBus.irqMode = optIrqMode_r;
  assign wdtTimeout = wdtBus.timeout;

  wdt_counter #(
    .CYC0(WDT_CYC0),
    .CYC1(WDT_CYC1),
    .CYC2(WDT_CYC2),
    .CYC3(WDT_CYC3)
  ) u_wdt (
    .clk(clk),
    .rstn(rstn),
    .w(wdtBus)
  );

  // timeout wins over a same-cycle clear instruction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timeoutStatus_r <= `RST_TIMEOUT;
    end else if (wdtTimeout) begin
      timeoutStatus_r <= 1'b0;
    end else if (wdtBus.clear) begin
      timeoutStatus_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdtResetReq <= 1'b0;
    end else begin
      wdtResetReq <= wdtTimeout && !optIrqMode_r;
    end
  end

  // ==========================================
  // port-B pin sampling
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_r <= 8'h00;
      pinSync_r <= 8'h00;
      pinPrev_r <= 8'h00;
      primeCnt_r <= 2'd0;
    end else begin
      pinMeta_r <= portBPins;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
      if (primeCnt_r != 2'd3) primeCnt_r <= primeCnt_r + 2'd1;
    end
  end

  // change detection stays quiet until the sync pipe holds real samples
  logic [7:0] changeMask;
  logic [7:0] pinChanged;
  logic portChange;
  logic extEdge;

  assign changeMask = changeEn_r & inputMask_r & {7'h7F, !eis_r};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign pinChanged[gi] = changeMask[gi] && (pinSync_r[gi] != pinPrev_r[gi]);
    end
  endgenerate
  assign portChange = (primeCnt_r == 2'd3) && (|pinChanged);
  // edge select one picks rising, zero falling
  assign extEdge = (primeCnt_r == 2'd3) && eis_r &&
    (edgeSel_r ? (pinSync_r[0] && !pinPrev_r[0]) : (!pinSync_r[0] && pinPrev_r[0]));

  // ==========================================
  // sticky flags
  irq_bits_t setVec;
  always_comb begin
    setVec = 8'h00;
    setVec[`BIT_UPCNT] = upcounterOverflow;
    setVec[`BIT_DNCNT] = downcounterUnderflow;
    setVec[`BIT_WDTIRQ] = wdtTimeout && optIrqMode_r;
    setVec[`BIT_PORTCHG] = portChange;
    setVec[`BIT_EXTIRQ] = extEdge;
  end

  always_comb begin
    flags_nxt = flags_r;
    if (wrFire && (wrSel == SEL_FLAG) && wStrb_r[0]) begin
      flags_nxt = flags_r & wData_r[7:0];
    end
    flags_nxt = (flags_nxt | setVec) & `FLAG_MASK;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================
  // global enable and vectoring
  logic hwTake;
  assign irqPending = |(flags_r & enable_r);
  assign hwTake = instrBoundary && gie_r && irqPending && !softIrqInstr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gie_r <= 1'b0;
    end else if (softIrqInstr || hwTake) begin
      gie_r <= 1'b0;
    end else if (enableIrqInstr || returnFromIsrInstr) begin
      gie_r <= 1'b1;
    end else if (disableIrqInstr) begin
      gie_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vectorValid <= 1'b0;
      vectorAddr <= 11'h000;
    end else begin
      vectorValid <= softIrqInstr || hwTake;
      if (softIrqInstr) begin
        vectorAddr <= `VEC_SOFT;
      end else if (hwTake) begin
        vectorAddr <= `VEC_HARD;
      end
    end
  end

  // ==========================================
  // checks
  a_soft_vector: assert property (@(posedge clk) disable iff (!rstn)
    softIrqInstr |=> vectorValid && (vectorAddr == `VEC_SOFT) && !gie_r)
    else $error("software interrupt did not vector to 0x001");

  a_hard_vector: assert property (@(posedge clk) disable iff (!rstn)
    (instrBoundary && gie_r && irqPending && !softIrqInstr)
      |=> vectorValid && (vectorAddr == `VEC_HARD) && !gie_r)
    else $error("pending interrupt did not vector to 0x008");

  a_gie_gate: assert property (@(posedge clk) disable iff (!rstn)
    (!gie_r && !softIrqInstr) |=> !vectorValid)
    else $error("vector issued with global enable clear");

  a_gie_return: assert property (@(posedge clk) disable iff (!rstn)
    (returnFromIsrInstr && !softIrqInstr && !hwTake) |=> gie_r)
    else $error("return did not set global enable");

  a_boundary_only: assert property (@(posedge clk) disable iff (!rstn)
    (!instrBoundary && !softIrqInstr) |=> !vectorValid)
    else $error("vector outside instruction boundary");

  a_event_wins: assert property (@(posedge clk) disable iff (!rstn)
    upcounterOverflow |=> flags_r[`BIT_UPCNT])
    else $error("up-counter event lost");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (flags_r[`BIT_DNCNT] && !(wrFire && wrSel == SEL_FLAG)) |=> flags_r[`BIT_DNCNT])
    else $error("flag dropped without a write");

  a_read_masked: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready && rdSel == SEL_FLAG)
      |=> ((rdata_r[7:0] & ~$past(enable_r)) == 8'h00))
    else $error("flag visible while disabled");

  a_timeout_clears: assert property (@(posedge clk) disable iff (!rstn)
    wdtTimeout |=> !timeoutStatus_r)
    else $error("timeout left status flag set");

  a_timeout_route: assert property (@(posedge clk) disable iff (!rstn)
    wdtTimeout |=> (wdtResetReq != optIrqMode_r) &&
      (flags_r[`BIT_WDTIRQ] == optIrqMode_r || $past(flags_r[`BIT_WDTIRQ])))
    else $error("timeout routed wrongly");

  a_eis_blocks: assert property (@(posedge clk) disable iff (!rstn)
    (eis_r && (pinChanged[7:1] == 7'h00)) |-> !portChange)
    else $error("pin 0 change counted with external irq selected");

  a_run_gate: assert property (@(posedge clk) disable iff (!rstn)
    !wdtBus.runEn |-> !wdtTimeout)
    else $error("watchdog expired while stopped");
endmodule

// File: tb/core_model.sv
`timescale 1ns/1ps
// ==========================================
// core sequencer stand-in: a boundary every cycle unless stalled
module core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic vectorValid,
  input wire logic [10:0] vectorAddr,
  output logic instrBoundary,
  output logic [7:0] nVec,
  output logic [10:0] lastVec
);
  assign instrBoundary = rstn && !stall;
  // vector log, cleared with the device so counts restart per run
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nVec <= 8'h00;
      lastVec <= 11'h000;
    end else if (vectorValid) begin
      nVec <= nVec + 8'h01;
      lastVec <= vectorAddr;
    end
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "wdt_irq_params.svh"
module tb;
  typedef struct {logic [31:0] cfg; logic [31:0] en; logic [7:0] pins; logic [6:0] ev;
    logic [31:0] exp;} row_t;
  logic clk, rstn, stall, awvalid, wvalid, bready, arvalid, rready, irqMode;
  logic awready, wready, bvalid, arready, rvalid, vectorValid, wdtResetReq, irqPending;
  logic instrBoundary;
  logic wdtOpt;
  logic [3:0] strb;
  logic [7:0] awaddr, araddr, pins, nVec;
  logic [31:0] wdata, rdata, rv;
  logic [10:0] vectorAddr, lastVec;
  logic [6:0] ev;
  logic [1:0] per, br, rr, bresp, rresp;
  int nMismatch = 0;
  int nTests = 0;
  int c;
  row_t rows [7] = '{
    '{32'h0000_0000, 32'h0000_0001, 8'h00, 7'h01, 32'h0000_0001},
    '{32'h0000_0000, 32'h0000_0000, 8'h00, 7'h01, 32'h0000_0000},
    '{32'h0000_0000, 32'h0000_0008, 8'h00, 7'h02, 32'h0000_0008},
    '{32'h0000_0808, 32'h0000_0002, 8'h08, 7'h00, 32'h0000_0002},
    '{32'h0000_0800, 32'h0000_0002, 8'h08, 7'h00, 32'h0000_0000},
    '{32'h0003_0000, 32'h0000_0004, 8'h01, 7'h00, 32'h0000_0004},
    '{32'h0001_0101, 32'h0000_0006, 8'h01, 7'h00, 32'h0000_0000}};

  // small counts keep the watchdog runs short
  watchdog_and_interrupt_unit #(.WDT_CYC0(20), .WDT_CYC1(30), .WDT_CYC2(40), .WDT_CYC3(50))
  dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cfgWdtEnable(wdtOpt), .cfgWdtIrqMode(irqMode), .cfgWdtPeriod(per),
    .instrBoundary(instrBoundary), .watchdogClearInstr(ev[2]), .enableIrqInstr(ev[3]),
    .disableIrqInstr(ev[4]), .softIrqInstr(ev[5]), .returnFromIsrInstr(ev[6]),
    .upcounterOverflow(ev[0]), .downcounterUnderflow(ev[1]), .portBPins(pins),
    .vectorValid(vectorValid), .vectorAddr(vectorAddr), .wdtResetReq(wdtResetReq),
    .irqPending(irqPending));
  core_model core_u (.clk(clk), .rstn(rstn), .stall(stall), .vectorValid(vectorValid),
    .vectorAddr(vectorAddr), .instrBoundary(instrBoundary), .nVec(nVec), .lastVec(lastVec));

  // ==========================================
  // helpers: all timed tasks start and end just after a rising edge
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("mismatches %0d of %0d checks", nMismatch, nTests);
    if (nMismatch == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // handshakes decided at the falling edge, where ready and valid are settled
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      br = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      k++;
    end while (tb !== 1'b1 && k < 50);
    // bready stays high: lowering it here would clash with the next call's raise
    if (tb !== 1'b1) nMismatch++;
  endtask
  task rs(input logic [7:0] a);
    logic ta, tr;
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      k++;
    end while (tr !== 1'b1 && k < 50);
    if (tr !== 1'b1) nMismatch++;
  endtask
  task pl(input logic [6:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
    @(posedge clk);
  endtask
  task wdw(input int lim);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (wdtResetReq !== 1'b1 && c < lim);
    @(posedge clk);
  endtask
  task rst;
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // ==========================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    nMismatch++;
    conclude();
  end
  initial begin
    {rstn, stall, awvalid, wvalid, bready, arvalid, rready, irqMode} = '0;
    {awaddr, araddr, pins, wdata, ev, per} = '0;
    strb = 4'hF;
    wdtOpt = 1'b1;
    @(posedge clk);
    rst();
    rs(`OFS_STATUS);
    chk({rv[4], rv[0]}, 2'b10);
    rs(`OFS_POWER_CTRL);
    chk(rv[7], 1'b1);
    axw(8'h40, 32'h0000_00FF);
    chk(br, `RESP_SLVERR);
    rs(8'h40);
    chk({rr, rv}, {`RESP_SLVERR, 32'h0000_0000});
    // no byte lanes: the enable register must keep its reset value
    strb <= 4'h0;
    axw(`OFS_IRQ_ENABLE, 32'h0000_00FF);
    strb <= 4'hF;
    rs(`OFS_IRQ_ENABLE);
    chk(rv, 32'h0000_0000);
    foreach (rows[i]) begin
      axw(`OFS_PORTB_CFG, rows[i].cfg);
      axw(`OFS_IRQ_ENABLE, rows[i].en);
      pins <= rows[i].pins;
      pl(rows[i].ev);
      repeat (6) @(posedge clk);
      rs(`OFS_IRQ_FLAG);
      chk(rv, rows[i].exp);
      axw(`OFS_PORTB_CFG, 32'h0000_0000);
      pins <= 8'h00;
      repeat (6) @(posedge clk);
      axw(`OFS_IRQ_FLAG, 32'h0000_0000);
    end
    axw(`OFS_IRQ_ENABLE, 32'h0000_0001);
    pl(7'h01);
    @(negedge clk);
    chk(irqPending, 1'b1);
    repeat (3) @(posedge clk);
    chk(nVec, 8'h00);
    stall <= 1'b1;
    pl(7'h08);
    repeat (4) @(posedge clk);
    chk(nVec, 8'h00);
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    chk({nVec, 3'h0, lastVec}, {8'h01, 14'h0008});
    rs(`OFS_STATUS);
    chk(rv[0], 1'b0);
    axw(`OFS_IRQ_FLAG, 32'h0000_0000);
    // service routine ends with return, no enable just before it
    pl(7'h40);
    rs(`OFS_STATUS);
    chk({nVec, rv[0]}, {8'h01, 1'b1});
    pl(7'h10);
    rs(`OFS_STATUS);
    chk(rv[0], 1'b0);
    pl(7'h20);
    repeat (3) @(posedge clk);
    chk({nVec, 3'h0, lastVec}, {8'h02, 14'h0001});
    wdw(200);
    chk(c < 200, 1'b1);
    repeat (2) @(posedge clk);
    rs(`OFS_STATUS);
    chk(rv[4], 1'b0);
    // first wait lines up on a pulse, second one measures a full period
    wdw(200);
    wdw(200);
    chk(c, 20);
    axw(`OFS_PRESCALE, 32'h0000_000B);
    pl(7'h04);
    rs(`OFS_STATUS);
    chk(rv[4], 1'b1);
    wdw(400);
    wdw(400);
    chk(c, 160);
    axw(`OFS_POWER_CTRL, 32'h0000_0000);
    wdw(400);
    chk(c, 400);
    // options are latched only after reset, so mode change needs a new one
    irqMode <= 1'b1;
    per <= 2'h1;
    rst();
    axw(`OFS_IRQ_ENABLE, 32'h0000_0040);
    axw(`OFS_PRESCALE, 32'h0000_0008);
    wdw(200);
    chk(c, 200);
    rs(`OFS_IRQ_FLAG);
    chk(rv, 32'h0000_0040);
    pl(7'h08);
    repeat (4) @(posedge clk);
    chk({nVec, 3'h0, lastVec}, {8'h01, 14'h0008});
    // the two longer base periods, back in reset mode
    irqMode <= 1'b0;
    for (int p = 2; p < 4; p++) begin
      per <= 2'(p);
      rst();
      wdw(200);
      wdw(200);
      chk(c, 20 + 10 * p);
    end
    // option off: the run bit alone must not start the watchdog
    wdtOpt <= 1'b0;
    rst();
    wdw(200);
    chk(c, 200);
    conclude();
  end
endmodule
